// >>> rtl/nams_pkg.sv
package nams_pkg;
  // decimal switch codes
  localparam logic [9:0] SW_DEFAULT   = 10'h000;
  localparam logic [9:0] SW_STAT_MIN  = 10'h002;
  localparam logic [9:0] SW_STAT_MAX  = 10'h0FE;
  localparam logic [9:0] SW_BOOTP     = 10'h12C;
  localparam logic [9:0] SW_DHCP      = 10'h190;
  localparam logic [9:0] SW_TOOL      = 10'h1F4;
  localparam logic [9:0] SW_DHCP_ONCE = 10'h258;
  localparam logic [9:0] SW_FACTORY   = 10'h384;
  // default network settings
  localparam logic [31:0] DEF_IP      = 32'hC0A801FE;
  localparam logic [31:0] DEF_MASK    = 32'hFFFFFF00;
  localparam logic [31:0] DEF_GW      = 32'hC0A80101;
  // button debounce time
  localparam int DEBOUNCE_NS  = 10000000;
  localparam int CLK_NS       = 50;
  localparam int DEBOUNCE_CYC = DEBOUNCE_NS / CLK_NS;

  typedef enum logic [3:0] {
    NAMS_NONE     = 4'h0,
    NAMS_STATIC   = 4'h1,
    NAMS_BOOTP    = 4'h2,
    NAMS_DHCP     = 4'h3,
    NAMS_TOOL     = 4'h4,
    NAMS_ONCE     = 4'h5,
    NAMS_DEFAULT  = 4'h6,
    NAMS_FACTORY  = 4'h7,
    NAMS_UNUSED   = 4'h8
  } nams_mode_e;

  typedef enum logic [2:0] {
    NAMS_ST_SAMPLE = 3'h0,
    NAMS_ST_LOAD   = 3'h1,
    NAMS_ST_RUN    = 3'h2,
    NAMS_ST_STORE  = 3'h3,
    NAMS_ST_ERASE  = 3'h4
  } nams_state_e;
endpackage

// >>> rtl/nams_top.sv
module nams_top #(
  parameter bit HAS_SWITCHES = 1'b1,
  parameter int DEBOUNCE     = nams_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // rotary switches, bcd digits, and push button
  input  wire logic [3:0]  sw_hund_in,
  input  wire logic [3:0]  sw_tens_in,
  input  wire logic [3:0]  sw_ones_in,
  input  wire logic        button_in,
  // nonvolatile store
  input  wire logic [31:0] nv_ip_in,
  input  wire logic [31:0] nv_mask_in,
  input  wire logic [31:0] nv_gw_in,
  input  wire logic        nv_once_done_in,
  input  wire logic        nv_ready_in,
  output logic             nv_read_out,
  output logic             nv_write_out,
  output logic             nv_erase_out,
  output logic             nv_once_done_out,
  // address server client
  input  wire logic        srv_bound_in,
  input  wire logic [31:0] srv_ip_in,
  input  wire logic [31:0] srv_mask_in,
  input  wire logic        tool_write_in,
  input  wire logic [31:0] tool_ip_in,
  input  wire logic [31:0] tool_mask_in,
  input  wire logic [31:0] tool_gw_in,
  output logic             bootp_en_out,
  output logic             dhcp_en_out,
  // resulting settings
  output logic [31:0]      ip_out,
  output logic [31:0]      mask_out,
  output logic [31:0]      gw_out,
  output logic [31:0]      store_ip_out,
  output logic [31:0]      store_mask_out,
  output logic [31:0]      store_gw_out,
  output logic [3:0]       mode_out,
  output logic             restart_out,
  output logic             ready_out
);

  typedef struct packed {
    logic [3:0]  h1, t1, o1;
    logic [3:0]  h2, t2, o2;
    logic        b1, b2, b_last;
    logic [23:0] db_cnt;
    logic        b_stable;
    nams_pkg::nams_state_e st;
    nams_pkg::nams_mode_e  mode;
    logic [9:0]  sw_val;
    logic        nv_read, nv_write, nv_erase, nv_once;
    logic        bootp_en, dhcp_en;
    logic [31:0] ip, mask, gw;
    logic [31:0] s_ip, s_mask, s_gw;
    logic        restart, ready;
  } nams_state_s;

  nams_state_s q, d;

  function automatic logic [9:0] nams_bcd(input logic [3:0] h, input logic [3:0] t,
                                          input logic [3:0] o);
    nams_bcd = 10'(h * 100) + 10'(t * 10) + 10'(o);
  endfunction

  function automatic nams_pkg::nams_mode_e nams_decode(input logic [9:0] v);
    if (v == nams_pkg::SW_DEFAULT) begin
      nams_decode = nams_pkg::NAMS_DEFAULT;
    end else if (v >= 10'h001 && v <= 10'h0FF) begin
      nams_decode = nams_pkg::NAMS_STATIC;
    end else if (v == nams_pkg::SW_BOOTP) begin
      nams_decode = nams_pkg::NAMS_BOOTP;
    end else if (v == nams_pkg::SW_DHCP) begin
      nams_decode = nams_pkg::NAMS_DHCP;
    end else if (v == nams_pkg::SW_TOOL) begin
      nams_decode = nams_pkg::NAMS_TOOL;
    end else if (v == nams_pkg::SW_DHCP_ONCE) begin
      nams_decode = nams_pkg::NAMS_ONCE;
    end else if (v == nams_pkg::SW_FACTORY) begin
      nams_decode = nams_pkg::NAMS_FACTORY;
    end else begin
      nams_decode = nams_pkg::NAMS_UNUSED;
    end
  endfunction

  logic server_mode;
  assign server_mode = (q.mode == nams_pkg::NAMS_BOOTP) || (q.mode == nams_pkg::NAMS_DHCP) ||
                       (q.mode == nams_pkg::NAMS_ONCE);

  always_comb begin
    d = q;
    // pins pass two flops before use
    d.h1 = sw_hund_in;
    d.t1 = sw_tens_in;
    d.o1 = sw_ones_in;
    d.h2 = q.h1;
    d.t2 = q.t1;
    d.o2 = q.o1;
    d.b1 = button_in;
    d.b2 = q.b1;
    d.nv_read = 1'b0;
    d.nv_write = 1'b0;
    d.nv_erase = 1'b0;
    d.restart = 1'b0;
    // debounce the button so contact bounce cannot retrigger a restart
    if (q.b2 != q.b_last) begin
      d.b_last = q.b2;
      d.db_cnt = '0;
    end else if (q.db_cnt != 24'(DEBOUNCE)) begin
      d.db_cnt = q.db_cnt + 24'h000001;
    end else begin
      d.b_stable = q.b_last;
    end
    case (q.st)
      nams_pkg::NAMS_ST_SAMPLE: begin
        // wait for the switch synchroniser to fill, then latch once
        if (q.db_cnt == 24'h000003) begin
          d.sw_val = nams_bcd(q.h2, q.t2, q.o2);
          d.mode = HAS_SWITCHES ? nams_decode(nams_bcd(q.h2, q.t2, q.o2))
                                : nams_pkg::NAMS_ONCE;
          d.st = nams_pkg::NAMS_ST_LOAD;
          d.nv_read = 1'b1;
        end
      end
      nams_pkg::NAMS_ST_LOAD: begin
        if (nv_ready_in) begin
          // every mode except default and factory starts from the stored settings
          d.ip = nv_ip_in;
          d.mask = nv_mask_in;
          d.gw = nv_gw_in;
          d.nv_once = nv_once_done_in;
          d.s_ip = nv_ip_in;
          d.s_mask = nv_mask_in;
          d.s_gw = nv_gw_in;
          d.st = nams_pkg::NAMS_ST_RUN;
          d.ready = 1'b1;
          case (q.mode)
            nams_pkg::NAMS_STATIC: begin
              d.ip = {nv_ip_in[31:8], q.sw_val[7:0]};
            end
            nams_pkg::NAMS_BOOTP: begin
              d.bootp_en = 1'b1;
            end
            nams_pkg::NAMS_DHCP: begin
              d.dhcp_en = 1'b1;
            end
            nams_pkg::NAMS_ONCE: begin
              d.dhcp_en = !nv_once_done_in;
            end
            nams_pkg::NAMS_DEFAULT, nams_pkg::NAMS_FACTORY: begin
              d.ip = nams_pkg::DEF_IP;
              d.mask = nams_pkg::DEF_MASK;
              d.gw = nams_pkg::DEF_GW;
              d.s_ip = nams_pkg::DEF_IP;
              d.s_mask = nams_pkg::DEF_MASK;
              d.s_gw = nams_pkg::DEF_GW;
              d.nv_once = 1'b0;
              d.ready = 1'b0;
              d.st = (q.mode == nams_pkg::NAMS_FACTORY) ? nams_pkg::NAMS_ST_ERASE
                                                         : nams_pkg::NAMS_ST_STORE;
            end
            default: begin
              d.bootp_en = 1'b0;
              d.dhcp_en = 1'b0;
            end
          endcase
        end
      end
      nams_pkg::NAMS_ST_ERASE: begin
        d.nv_erase = 1'b1;
        d.st = nams_pkg::NAMS_ST_STORE;
      end
      nams_pkg::NAMS_ST_STORE: begin
        d.nv_write = 1'b1;
        d.ready = 1'b1;
        d.st = nams_pkg::NAMS_ST_RUN;
      end
      nams_pkg::NAMS_ST_RUN: begin
        if (server_mode && srv_bound_in && (q.bootp_en || q.dhcp_en)) begin
          d.ip = srv_ip_in;
          d.mask = srv_mask_in;
          d.s_ip = srv_ip_in;
          d.s_mask = srv_mask_in;
          d.s_gw = q.gw;
          d.nv_write = 1'b1;
          if (q.mode == nams_pkg::NAMS_ONCE) begin
            d.dhcp_en = 1'b0;
            d.nv_once = 1'b1;
          end
        end else if (q.mode == nams_pkg::NAMS_TOOL && tool_write_in) begin
          d.ip = tool_ip_in;
          d.mask = tool_mask_in;
          d.gw = tool_gw_in;
          d.s_ip = tool_ip_in;
          d.s_mask = tool_mask_in;
          d.s_gw = tool_gw_in;
          d.nv_write = 1'b1;
        end
      end
      default: begin
        d.st = nams_pkg::NAMS_ST_SAMPLE;
      end
    endcase
    // a debounced press restarts everything: it resamples the switches, or with HAS_SWITCHES off it enters factory mode
    if (d.b_stable && !q.b_stable) begin
      d.restart = 1'b1;
      d.ready = 1'b0;
      d.bootp_en = 1'b0;
      d.dhcp_en = 1'b0;
      d.nv_write = 1'b0;
      d.nv_erase = 1'b0;
      d.nv_read = 1'b0;
      d.db_cnt = '0;
      d.st = nams_pkg::NAMS_ST_SAMPLE;
      if (!HAS_SWITCHES) begin
        d.mode = nams_pkg::NAMS_FACTORY;
        d.st = nams_pkg::NAMS_ST_LOAD;
        d.nv_read = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign nv_read_out      = q.nv_read;
  assign nv_write_out     = q.nv_write;
  assign nv_erase_out     = q.nv_erase;
  assign nv_once_done_out = q.nv_once;
  assign bootp_en_out     = q.bootp_en;
  assign dhcp_en_out      = q.dhcp_en;
  assign ip_out           = q.ip;
  assign mask_out         = q.mask;
  assign gw_out           = q.gw;
  assign store_ip_out     = q.s_ip;
  assign store_mask_out   = q.s_mask;
  assign store_gw_out     = q.s_gw;
  assign mode_out         = q.mode;
  assign restart_out      = q.restart;
  assign ready_out        = q.ready;

endmodule

// >>> testbench/nams_top_properties.sv
module nams_top_properties (
  input wire logic        clk_in, reset_in, nv_ready_in, srv_bound_in,
  input wire logic        nv_read_out, nv_write_out, nv_erase_out, nv_once_done_out,
  input wire logic        bootp_en_out, dhcp_en_out, restart_out, ready_out,
  input wire logic [31:0] srv_ip_in, ip_out, mask_out, gw_out,
  input wire logic [3:0]  mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_rd_pulse; nv_read_out |=> !nv_read_out; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
  property p_load; $rose(ready_out) && mode_out inside {4'h1, 4'h4} |-> $past(nv_ready_in);
  endproperty
  a_load: assert property (p_load) else $error("ready without stored data");
  property p_server;
    srv_bound_in && (bootp_en_out || dhcp_en_out) |=> nv_write_out && ip_out == $past(srv_ip_in);
  endproperty
  a_server: assert property (p_server) else $error("server address not stored");
  property p_bootp; $rose(ready_out) && mode_out == 4'h2 |-> bootp_en_out && !dhcp_en_out;
  endproperty
  a_bootp: assert property (p_bootp) else $error("bootp client not started");
  property p_dhcp; $rose(ready_out) && mode_out == 4'h3 |-> dhcp_en_out && !bootp_en_out;
  endproperty
  a_dhcp: assert property (p_dhcp) else $error("dhcp client not started");
  property p_once; mode_out == 4'h5 && nv_once_done_out |-> !dhcp_en_out; endproperty
  a_once: assert property (p_once) else $error("requests after once done");
  property p_quiet; mode_out inside {4'h1, 4'h4, 4'h8} |-> !(bootp_en_out || dhcp_en_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("client enabled in quiet mode");
  property p_def; ready_out && mode_out inside {4'h6, 4'h7} |-> ip_out == nams_pkg::DEF_IP
    && mask_out == nams_pkg::DEF_MASK && gw_out == nams_pkg::DEF_GW;
  endproperty
  a_def: assert property (p_def) else $error("defaults not restored");
  property p_erase; nv_erase_out |-> mode_out == 4'h7 ##1 !nv_erase_out ##[0:2] nv_write_out;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not followed by write");
  property p_restart; restart_out |=> !restart_out; endproperty
  a_restart: assert property (p_restart) else $error("restart pulse too long");
  c_once: cover property (mode_out == 4'h5 && nv_write_out);
  c_erase: cover property (nv_erase_out);
  c_restart: cover property (restart_out);
endmodule

// >>> testbench/nams_far_end.sv
module nams_far_end #(
  parameter logic [31:0] SRV_IP = 32'h0A000033,
  parameter int          LAT    = 2
) (
  input  wire logic        clk_in, nv_read_out, nv_write_out, nv_erase_out, nv_once_done_out,
  input  wire logic        bootp_en_out, dhcp_en_out, ready_out,
  input  wire logic [31:0] store_ip_out, store_mask_out, store_gw_out,
  output logic             nv_ready_in, nv_once_done_in, srv_bound_in,
  output logic [31:0]      nv_ip_in, nv_mask_in, nv_gw_in, srv_ip_in, srv_mask_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int   wait_q;
  logic served_q;
  // offer lines show garbage outside the grant cycle
  assign srv_ip_in   = srv_bound_in ? SRV_IP : ~SRV_IP;
  assign srv_mask_in = srv_bound_in ? 32'hFFFF0000 : 32'h0000FFFF;
  initial begin
    {nv_ready_in, srv_bound_in, served_q, nv_once_done_in} = '0;
    {nv_ip_in, nv_mask_in, nv_gw_in} = '0;
    wait_q = 0;
  end
  always @(posedge clk_in) begin
    wait_q <= nv_read_out ? LAT : (wait_q > 0 ? wait_q - 1 : 0);
    if (wait_q == 1) nv_ready_in <= 1'b1;
    if (ready_out) nv_ready_in <= 1'b0;
    // one grant per boot, like a server answering a single request
    srv_bound_in <= (bootp_en_out || dhcp_en_out) && ready_out && !served_q && !srv_bound_in;
    served_q <= nv_read_out ? 1'b0 : (served_q || srv_bound_in);
    if (nv_erase_out) {nv_ip_in, nv_mask_in, nv_gw_in, nv_once_done_in} <= '0;
    if (nv_write_out) begin
      {nv_ip_in, nv_mask_in, nv_gw_in} <= {store_ip_out, store_mask_out, store_gw_out};
      nv_once_done_in <= nv_once_done_out;
    end
  end
endmodule

// >>> testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, reset_in, button_in, tool_write_in, nv_once_done_in, nv_ready_in;
  logic        srv_bound_in, nv_read_out, nv_write_out, nv_erase_out, nv_once_done_out;
  logic        bootp_en_out, dhcp_en_out, restart_out, ready_out;
  logic [3:0]  sw_hund_in, sw_tens_in, sw_ones_in, mode_out;
  logic [31:0] tool_ip_in, tool_mask_in, tool_gw_in, nv_ip_in, nv_mask_in, nv_gw_in;
  logic [31:0] srv_ip_in, srv_mask_in, ip_out, mask_out, gw_out;
  logic [31:0] store_ip_out, store_mask_out, store_gw_out;
  int          fail_count = 0;
  int          n_checks = 0;
  int          tn = 0;
  localparam logic [31:0] SIP = 32'h0A000033;
  localparam logic [31:0] TIP = 32'h0A141E28;
  nams_top #(.DEBOUNCE(4)) i_dut (.*);
  nams_far_end #(.SRV_IP(SIP)) i_far (.*);
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("test %0d ended; checks %0d mismatches %0d", tn, n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // 0 ready, 1 nv write, 2 restart, 3 nv read
  task automatic await(input int w);
    int n;
    n = 0;
    while (!(w == 0 ? ready_out : w == 1 ? nv_write_out : w == 2 ? restart_out : nv_read_out))
    begin
      @(negedge clk_in);
      if (++n > 200) begin
        fail_count++;
        $display("Error at %0t: wait %h got %h", $time, w, n);
        print_verdict();
      end
    end
  endtask
  task automatic boot(input logic [3:0] h, t, o, m);
    if (tn++ > 0) $display("test %0d ended", tn - 1);
    @(negedge clk_in);
    {sw_hund_in, sw_tens_in, sw_ones_in} = {h, t, o};
    reset_in = 1'b1;
    repeat (10) @(negedge clk_in);
    reset_in = 1'b0;
    await(0);
    chk(mode_out, m);
  endtask
  initial begin
    // hold reset from time zero so the design never runs on unknown state
    reset_in = 1'b1;
    {button_in, tool_write_in} = '0;
    {sw_hund_in, sw_tens_in, sw_ones_in} = '0;
    {tool_ip_in, tool_mask_in, tool_gw_in} = '0;
    boot(0, 0, 0, 6);
    chk(mask_out, nams_pkg::DEF_MASK);
    chk(gw_out, nams_pkg::DEF_GW);
    boot(1, 2, 3, 1);
    chk(ip_out, {nams_pkg::DEF_IP[31:8], 8'h7B});
    sw_hund_in = 4'h4;
    repeat (20) @(negedge clk_in);
    chk(mode_out, 4'h1);
    boot(4, 0, 0, 3);
    await(1);
    chk(ip_out, SIP);
    chk(mask_out, 32'hFFFF0000);
    boot(3, 0, 0, 2);
    chk(bootp_en_out, 1'b1);
    boot(2, 8, 0, 8);
    chk(ip_out, SIP);
    boot(6, 0, 0, 5);
    await(1);
    chk({dhcp_en_out, nv_once_done_out}, 2'h1);
    boot(6, 0, 0, 5);
    repeat (8) @(negedge clk_in);
    chk(32'(dhcp_en_out), 32'h00000000);
    chk(ip_out, SIP);
    boot(5, 0, 0, 4);
    {tool_ip_in, tool_mask_in, tool_gw_in} = {TIP, 32'hFFFFFF00, 32'h0A141E01};
    tool_write_in = 1'b1;
    @(negedge clk_in);
    tool_write_in = 1'b0;
    await(1);
    chk(ip_out, TIP);
    {sw_hund_in, button_in} = {4'h1, 1'b1};
    await(2);
    button_in = 1'b0;
    await(3);
    @(negedge clk_in);
    await(0);
    chk(ip_out, 32'h0A141E64);
    boot(9, 0, 0, 7);
    chk(ip_out, nams_pkg::DEF_IP);
    boot(1, 0, 0, 1);
    chk(ip_out, 32'hC0A80164);
    print_verdict();
  end
endmodule
bind nams_top nams_top_properties i_props (.clk_in, .reset_in, .nv_ready_in, .srv_bound_in,
  .nv_read_out, .nv_write_out, .nv_erase_out, .nv_once_done_out, .bootp_en_out, .dhcp_en_out,
  .restart_out, .ready_out, .srv_ip_in, .ip_out, .mask_out, .gw_out, .mode_out);
